// >>> pkg/tpcs_pkg.sv
// constants and types shared by the timer pair clocking and split block
package tpcs_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [19:0] ADDR_FILTER_EN = 20'hF_0071;
  localparam logic [19:0] ADDR_PORT0_DIR = 20'hF_FF20;
  localparam logic [19:0] ADDR_PRESCALE = 20'hF_0180;
  localparam logic [19:0] ADDR_MODE0 = 20'hF_0181;
  localparam logic [19:0] ADDR_MODE1 = 20'hF_0182;
  localparam logic [19:0] ADDR_START = 20'hF_0183;
  localparam logic [19:0] ADDR_STOP = 20'hF_0184;
  localparam logic [19:0] ADDR_STATUS = 20'hF_0185;
  localparam logic [19:0] ADDR_RELOAD0_LO = 20'hF_0186;
  localparam logic [19:0] ADDR_RELOAD0_HI = 20'hF_0187;
  localparam logic [19:0] ADDR_RELOAD1_LO = 20'hF_0188;
  localparam logic [19:0] ADDR_RELOAD1_HI = 20'hF_0189;
  localparam logic [19:0] ADDR_COUNT0_LO = 20'hF_018A;
  localparam logic [19:0] ADDR_COUNT0_HI = 20'hF_018B;
  localparam logic [19:0] ADDR_COUNT1_LO = 20'hF_018C;
  localparam logic [19:0] ADDR_COUNT1_HI = 20'hF_018D;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] RST_FILTER_EN = 8'h00;
  localparam logic [7:0] RST_PORT0_DIR = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int PORT0_PINS = 5;
  localparam int TRIG_CH0 = 0;
  localparam int TRIG_CH1 = 1;
  localparam int TRIG_UPPER = 2;
  localparam int STAT_OUT0 = 4;
  localparam int STAT_OUT1 = 5;

  // ==========================================================
  // channel mode field encodings
  localparam logic [1:0] MODE_INTERVAL = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_DELAY = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // ==========================================================
  // types
  typedef struct packed {
    logic clk_sel;
    logic rsv;
    logic split;
    logic combine;
    logic src_sel;
    logic start_int;
    logic [1:0] mode;
  } tpcs_mode_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpcs_bus_t;

  typedef enum logic [1:0] {ST_STOP, ST_ARM, ST_RUN, ST_HOLD} tpcs_state_t;

endpackage

// >>> rtl/tpcs_prescaler.sv
// free running divider giving two selectable one-cycle operation clock enables
`timescale 1ns/1ps
module tpcs_prescaler #(
  parameter int DIV_BITS = 15
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // divider exponents, 0 means undivided
  input wire logic [3:0] i_exp_a,
  input wire logic [3:0] i_exp_b,
  // operation clock enables
  output logic [1:0] o_tick
);
  generate
    if (DIV_BITS < 1 || DIV_BITS > 15)
    begin : g_bad
      $error("prescaler width must be 1 to 15");
    end
  endgenerate

  logic [DIV_BITS-1:0] div_q;
  logic [DIV_BITS-1:0] div_d;
  logic [3:0] exps [2];

  assign div_d = div_q + {{(DIV_BITS-1){1'b0}}, 1'b1};
  assign exps[0] = i_exp_a;
  assign exps[1] = i_exp_b;

  // ==========================================================
  // divided selection is one clock high, undivided stays high
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sel
      wire [DIV_BITS-1:0] mask = ~({DIV_BITS{1'b1}} << exps[g]);
      assign o_tick[g] = (exps[g] == 4'h0) | (&(div_q | ~mask));
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      div_q <= '0;
    else
      div_q <= div_d;
  end
endmodule

// >>> rtl/tpcs_edge_sync.sv
// timer input pin synchroniser with optional match filter and rising edge detect
`timescale 1ns/1ps
module tpcs_edge_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // pin and filter control
  input wire logic i_pin,
  input wire logic i_filter_on,
  // rising edge pulse
  output logic o_edge
);
  logic s1_q;
  logic s2_q;
  logic h1_q;
  logic h2_q;
  logic lvl_q;
  logic lvl_d;
  logic match;

  // ==========================================================
  // filter needs three equal samples, otherwise two sync samples
  assign match = (s2_q == h1_q) && (h1_q == h2_q);
  assign lvl_d = i_filter_on ? (match ? h2_q : lvl_q) : s2_q;
  assign o_edge = lvl_d & ~lvl_q;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      h1_q <= 1'b0;
      h2_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      h1_q <= s2_q;
      h2_q <= h1_q;
      lvl_q <= lvl_d;
    end
  end
endmodule

// >>> rtl/tpcs_top.sv
// two channel timer with pairing, channel 1 split and count clock selection
//
// What this block does
// - per channel filter bit, 0 filter off, 1 filter on for its input pin.
// - filter on needs three matching samples, filter off two samples.
// - five port 0 direction bits, 0 output buffer on, 1 input; reset all ones.
// - only channel 0 acts as master; no master select bit exists.
// - slave channel 1 uses lower eight bits; upper eight are an interval timer only when split.
// - master forwards start trigger and count clock to the slave; its interrupt only in pwm, or delay when not split.
// - channel 1 split bit divides it into two eight bit timers.
// - upper half is interval only and interrupts at its start.
// - upper half uses the lower half operation clock select bit.
// - upper half has its own start, stop and status bits.
// - lower half runs interval, event, delay, pwm with normal triggers.
// - in sixteen bit mode upper start and stop are ignored.
// - split mode forbids one shot pairing and upper half reads.
// - count source bit picks operation clock or input pin edges.
// - operation clock spans divide by one to two to the fifteen.
// - counter updates one clock after each count clock pulse.
// - pin edge count clock lags one to two, or three to four filtered.
`timescale 1ns/1ps
module tpcs_top
  import tpcs_pkg::*;
#(
  parameter int DIV_BITS = 15
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // register port
  input wire logic [19:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // timer pins
  input wire logic [1:0] I_TIMER_IN,
  output logic [1:0] O_TIMER_OUT,
  output logic [tpcs_pkg::PORT0_PINS-1:0] O_PORT0_INPUT_MODE,
  // interrupts
  output logic O_MASTER_INT,
  output logic O_CH1_INT,
  output logic O_UPPER_INT
);
  import tpcs_pkg::*;

  // ==========================================================
  // registers
  tpcs_bus_t bus;
  logic [7:0] filter_en_q;
  logic [PORT0_PINS-1:0] port_dir_q;
  logic [7:0] prescale_q;
  tpcs_mode_t mode0_q;
  tpcs_mode_t mode1_q;
  logic [15:0] reload0_q;
  logic [15:0] reload1_q;
  logic [15:0] cnt0_q;
  logic [7:0] cnt1_lo_q;
  logic [7:0] cnt1_hi_q;
  logic [7:0] rdata_q;
  tpcs_state_t st0_q;
  tpcs_state_t st1_q;
  tpcs_state_t stu_q;
  logic [2:0] tick_q;
  logic [1:0] out_q;
  logic int0_q;
  logic int1_q;
  logic intu_q;

  // ==========================================================
  // decode
  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  wire hit_filter = bus.addr == ADDR_FILTER_EN;
  wire hit_dir = bus.addr == ADDR_PORT0_DIR;
  wire hit_pre = bus.addr == ADDR_PRESCALE;
  wire hit_mode0 = bus.addr == ADDR_MODE0;
  wire hit_mode1 = bus.addr == ADDR_MODE1;
  wire hit_status = bus.addr == ADDR_STATUS;
  wire hit_rl0_lo = bus.addr == ADDR_RELOAD0_LO;
  wire hit_rl0_hi = bus.addr == ADDR_RELOAD0_HI;
  wire hit_rl1_lo = bus.addr == ADDR_RELOAD1_LO;
  wire hit_rl1_hi = bus.addr == ADDR_RELOAD1_HI;
  wire hit_c0_lo = bus.addr == ADDR_COUNT0_LO;
  wire hit_c0_hi = bus.addr == ADDR_COUNT0_HI;
  wire hit_c1_lo = bus.addr == ADDR_COUNT1_LO;
  wire hit_c1_hi = bus.addr == ADDR_COUNT1_HI;
  wire wr_start = bus.wr && (bus.addr == ADDR_START);
  wire wr_stop = bus.wr && (bus.addr == ADDR_STOP);
  wire split = mode1_q.split;

  // ==========================================================
  // triggers
  wire start0 = wr_start && bus.wdata[TRIG_CH0];
  wire stop0 = wr_stop && bus.wdata[TRIG_CH0];
  // slave takes the master start trigger
  wire start1 = wr_start && (bus.wdata[TRIG_CH1] || (mode1_q.combine && bus.wdata[TRIG_CH0]));
  wire stop1 = wr_stop && bus.wdata[TRIG_CH1];
  // upper half triggers only act in split mode
  wire startu = wr_start && bus.wdata[TRIG_UPPER] && split;
  wire stopu = wr_stop && bus.wdata[TRIG_UPPER] && split;

  // ==========================================================
  // count clocks
  logic [1:0] op_tick;
  logic [1:0] pin_edge;

  tpcs_prescaler #(
    .DIV_BITS(DIV_BITS)
  ) u_pre (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_exp_a(prescale_q[3:0]),
    .i_exp_b(prescale_q[7:4]),
    .o_tick(op_tick)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      tpcs_edge_sync u_sync (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_pin(I_TIMER_IN[g]),
        .i_filter_on(filter_en_q[g]),
        .o_edge(pin_edge[g])
      );
    end
  endgenerate

  wire ck0 = op_tick[mode0_q.clk_sel];
  wire ck1 = op_tick[mode1_q.clk_sel];
  wire raw0 = mode0_q.src_sel ? pin_edge[0] : ck0;
  wire raw1_own = mode1_q.src_sel ? pin_edge[1] : ck1;
  wire raw1 = mode1_q.combine ? raw0 : raw1_own;
  wire tick0 = tick_q[0];
  wire tick1 = tick_q[1];
  wire ticku = tick_q[2];

  // ==========================================================
  // channel 0, always the master
  wire zero0 = cnt0_q == 16'h0000;
  wire arm_fire0 = tick0 && (st0_q == ST_ARM);
  wire run_zero0 = tick0 && (st0_q == ST_RUN) && zero0;
  wire int0_d = !stop0 && !start0 && ((arm_fire0 && mode0_q.start_int) || run_zero0);
  wire ld0 = !stop0 && ((start0 && mode0_q.mode == MODE_EVENT) || arm_fire0 || run_zero0);
  wire dec0 = !stop0 && !start0 && tick0 && (st0_q == ST_RUN) && !zero0;

  // ==========================================================
  // channel 1 lower half, slave of channel 0 when paired
  wire slave1 = mode1_q.combine && ((mode1_q.mode == MODE_PWM) || (mode1_q.mode == MODE_DELAY && !split));
  wire lo_only1 = split || mode1_q.combine;
  wire zero1 = lo_only1 ? (cnt1_lo_q == 8'h00) : ({cnt1_hi_q, cnt1_lo_q} == 16'h0000);
  wire sw1 = stop1 || start1;
  wire slave_trig = !sw1 && slave1 && int0_d && (st1_q != ST_STOP);
  wire arm_fire1 = !sw1 && !slave1 && tick1 && (st1_q == ST_ARM);
  wire run1 = !sw1 && !slave_trig && tick1 && (st1_q == ST_RUN);
  wire reload_mode1 = (mode1_q.mode == MODE_INTERVAL) || (mode1_q.mode == MODE_EVENT);
  wire run_zero1 = run1 && zero1;
  wire ld1 = (!stop1 && start1 && mode1_q.mode == MODE_EVENT) || slave_trig || arm_fire1
             || (run_zero1 && reload_mode1 && !slave1);
  wire dec1 = run1 && !zero1;
  wire int1_d = (arm_fire1 && mode1_q.start_int) || run_zero1;
  wire [15:0] cnt1_full_dec = {cnt1_hi_q, cnt1_lo_q} - 16'h0001;

  // ==========================================================
  // channel 1 upper half, split mode interval timer
  wire arm_fireu = split && !stopu && !startu && ticku && (stu_q == ST_ARM);
  wire run_zerou = split && !stopu && !startu && ticku && (stu_q == ST_RUN) && (cnt1_hi_q == 8'h00);
  wire ldu = arm_fireu || run_zerou;
  wire decu = split && !stopu && !startu && ticku && (stu_q == ST_RUN) && (cnt1_hi_q != 8'h00);
  wire intu_d = arm_fireu || run_zerou;

  // ==========================================================
  // read mux, upper half values are hidden in split mode
  wire [7:0] status = {2'b00, out_q[1], out_q[0], 1'b0, stu_q != ST_STOP, st1_q != ST_STOP, st0_q != ST_STOP};
  wire [7:0] upper_rd_rl = split ? 8'h00 : reload1_q[15:8];
  wire [7:0] upper_rd_cnt = split ? 8'h00 : cnt1_hi_q;
  wire [7:0] rd_d =
    hit_filter ? filter_en_q :
    hit_dir ? {3'b111, port_dir_q} :
    hit_pre ? prescale_q :
    hit_mode0 ? mode0_q :
    hit_mode1 ? mode1_q :
    hit_status ? status :
    hit_rl0_lo ? reload0_q[7:0] :
    hit_rl0_hi ? reload0_q[15:8] :
    hit_rl1_lo ? reload1_q[7:0] :
    hit_rl1_hi ? upper_rd_rl :
    hit_c0_lo ? cnt0_q[7:0] :
    hit_c0_hi ? cnt0_q[15:8] :
    hit_c1_lo ? cnt1_lo_q :
    hit_c1_hi ? upper_rd_cnt : 8'h00;

  // ==========================================================
  // software registers
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      filter_en_q <= RST_FILTER_EN;
      port_dir_q <= RST_PORT0_DIR[PORT0_PINS-1:0];
      prescale_q <= RST_BYTE;
      mode0_q <= RST_BYTE;
      mode1_q <= RST_BYTE;
      reload0_q <= {RST_BYTE, RST_BYTE};
      reload1_q <= {RST_BYTE, RST_BYTE};
    end
    else if (bus.wr)
    begin
      if (hit_filter)
        filter_en_q <= {6'b00_0000, bus.wdata[1:0]};
      if (hit_dir)
        port_dir_q <= bus.wdata[PORT0_PINS-1:0];
      if (hit_pre)
        prescale_q <= bus.wdata;
      if (hit_mode0)
        mode0_q <= {bus.wdata[7], 3'b000, bus.wdata[3:0]};
      if (hit_mode1)
        mode1_q <= {bus.wdata[7], 1'b0, bus.wdata[5:0]};
      if (hit_rl0_lo)
        reload0_q[7:0] <= bus.wdata;
      if (hit_rl0_hi)
        reload0_q[15:8] <= bus.wdata;
      if (hit_rl1_lo)
        reload1_q[7:0] <= bus.wdata;
      if (hit_rl1_hi)
        reload1_q[15:8] <= bus.wdata;
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      rdata_q <= RST_BYTE;
    else
      rdata_q <= bus.rd ? rd_d : 8'h00;
  end

  // ==========================================================
  // count clock pulses delayed one clock into the counters
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      tick_q <= 3'b000;
    else
      tick_q <= {ck1, raw1, raw0};
  end

  // ==========================================================
  // channel states
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      st0_q <= ST_STOP;
      st1_q <= ST_STOP;
      stu_q <= ST_STOP;
    end
    else
    begin
      if (stop0)
        st0_q <= ST_STOP;
      else if (start0)
        st0_q <= (mode0_q.mode == MODE_EVENT) ? ST_RUN : ST_ARM;
      else if (arm_fire0)
        st0_q <= ST_RUN;
      else if (run_zero0 && mode0_q.mode == MODE_DELAY)
        st0_q <= ST_HOLD;
      if (stop1)
        st1_q <= ST_STOP;
      else if (start1)
        st1_q <= (mode1_q.mode == MODE_EVENT) ? ST_RUN : ST_ARM;
      else if (slave_trig || arm_fire1)
        st1_q <= ST_RUN;
      else if (run_zero1 && !reload_mode1)
        st1_q <= ST_HOLD;
      else if (run_zero1 && slave1)
        st1_q <= ST_HOLD;
      if (stopu)
        stu_q <= ST_STOP;
      else if (startu)
        stu_q <= ST_ARM;
      else if (arm_fireu)
        stu_q <= ST_RUN;
    end
  end

  // ==========================================================
  // counters
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      cnt0_q <= {RST_BYTE, RST_BYTE};
      cnt1_lo_q <= RST_BYTE;
      cnt1_hi_q <= RST_BYTE;
    end
    else
    begin
      if (ld0)
        cnt0_q <= reload0_q;
      else if (dec0)
        cnt0_q <= cnt0_q - 16'h0001;
      if (ld1)
        cnt1_lo_q <= reload1_q[7:0];
      else if (dec1)
        cnt1_lo_q <= split ? cnt1_lo_q - 8'h01 : cnt1_full_dec[7:0];
      if (split)
      begin
        if (ldu)
          cnt1_hi_q <= reload1_q[15:8];
        else if (decu)
          cnt1_hi_q <= cnt1_hi_q - 8'h01;
      end
      else if (ld1)
        cnt1_hi_q <= reload1_q[15:8];
      else if (dec1)
        cnt1_hi_q <= cnt1_full_dec[15:8];
    end
  end

  // ==========================================================
  // interrupts and timer outputs
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      int0_q <= 1'b0;
      int1_q <= 1'b0;
      intu_q <= 1'b0;
      out_q <= 2'b00;
    end
    else
    begin
      int0_q <= int0_d;
      int1_q <= int1_d;
      intu_q <= intu_d;
      if (int0_d)
        out_q[0] <= ~out_q[0];
      if (slave_trig && mode1_q.mode == MODE_PWM)
        out_q[1] <= 1'b1;
      else if (int1_d)
        out_q[1] <= (mode1_q.mode == MODE_PWM && slave1) ? 1'b0 : ~out_q[1];
    end
  end

  // ==========================================================
  // outputs
  assign O_RDATA = rdata_q;
  assign O_TIMER_OUT = out_q;
  assign O_PORT0_INPUT_MODE = port_dir_q;
  assign O_MASTER_INT = int0_q;
  assign O_CH1_INT = int1_q;
  assign O_UPPER_INT = intu_q;
endmodule

// >>> bench/tpcs_chk.sv
// port checker for the timer pair clocking and split block
`timescale 1ns/1ps
module tpcs_chk
  import tpcs_pkg::*;
#(
  parameter int DIV_BITS = 15
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // register port
  input wire logic [19:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // timer pins and interrupts
  input wire logic [1:0] I_TIMER_IN,
  input wire logic [1:0] O_TIMER_OUT,
  input wire logic [tpcs_pkg::PORT0_PINS-1:0] O_PORT0_INPUT_MODE,
  input wire logic O_MASTER_INT,
  input wire logic O_CH1_INT,
  input wire logic O_UPPER_INT
);
  // ==========
  // register shadows
  logic [1:0] filt_q;
  logic split_q;
  logic up_q;
  wire wr_dir = I_WR && I_ADDR == ADDR_PORT0_DIR;
  wire wr_start = I_WR && I_ADDR == ADDR_START;
  wire mapped = I_ADDR == ADDR_FILTER_EN || I_ADDR == ADDR_PORT0_DIR ||
    (I_ADDR >= ADDR_PRESCALE && I_ADDR <= ADDR_COUNT1_HI);
  wire rd_hi = I_RD && split_q && (I_ADDR == ADDR_RELOAD1_HI || I_ADDR == ADDR_COUNT1_HI);
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      filt_q <= 2'h0;
      split_q <= 1'b0;
      up_q <= 1'b0;
    end
    else
    begin
      if (I_WR && I_ADDR == ADDR_FILTER_EN)
        filt_q <= I_WDATA[1:0];
      if (I_WR && I_ADDR == ADDR_MODE1)
        split_q <= I_WDATA[5];
      if (wr_start && I_WDATA[TRIG_UPPER] && split_q)
        up_q <= 1'b1;
    end
  end
  // ==========
  // properties
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  a_filter_read: assert property ($past(I_RD && I_ADDR == ADDR_FILTER_EN) |->
    O_RDATA == {6'h00, $past(filt_q)}) else $error("filter enable read mismatch");
  a_dir_write: assert property (wr_dir |=> O_PORT0_INPUT_MODE == $past(I_WDATA[4:0]))
    else $error("direction bits not written");
  a_dir_hold: assert property (!$past(wr_dir) |-> $stable(O_PORT0_INPUT_MODE))
    else $error("direction bits changed without write");
  a_dir_read: assert property (I_RD && I_ADDR == ADDR_PORT0_DIR |-> ##1
    O_RDATA == {3'h7, O_PORT0_INPUT_MODE}) else $error("direction read mismatch");
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (I_RD && !mapped |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_upper_hidden: assert property (rd_hi |=> O_RDATA == 8'h00)
    else $error("upper half register readable in split");
  a_upper_gated: assert property (O_UPPER_INT |-> up_q)
    else $error("upper interrupt without split start");
  c_master: cover property (O_MASTER_INT);
  c_slave: cover property (O_CH1_INT);
  c_upper: cover property (O_UPPER_INT);
endmodule

bind tpcs_top tpcs_chk #(.DIV_BITS(DIV_BITS)) u_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_TIMER_IN(I_TIMER_IN), .O_TIMER_OUT(O_TIMER_OUT), .O_PORT0_INPUT_MODE(O_PORT0_INPUT_MODE),
  .O_MASTER_INT(O_MASTER_INT), .O_CH1_INT(O_CH1_INT), .O_UPPER_INT(O_UPPER_INT));

// >>> bench/tpcs_pins.sv
// model of the sources driving the two timer input pins
`timescale 1ns/1ps
module tpcs_pins (
  // clock
  input wire logic i_clk,
  // pin levels
  output logic [1:0] o_pin
);
  initial o_pin = 2'h0;
  // pins are read as inputs, so levels change just after a rising edge
  task automatic drive(input int ch, input logic v);
  begin
    @(posedge i_clk);
    o_pin[ch] <= v;
  end
  endtask
endmodule

// >>> bench/test_tpcs_top.sv
// self checking bench for the timer pair clocking and split block
`timescale 1ns/1ps
module test_tpcs_top;
  import tpcs_pkg::*;
  localparam int DIVB = 4;
  logic clk = 1'b0;
  logic rst_b;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [1:0] tout;
  logic [4:0] pmode;
  wire [2:0] irq;
  wire logic [1:0] pin;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  tpcs_pins pins (.i_clk(clk), .o_pin(pin));
  tpcs_top #(.DIV_BITS(DIVB)) dut (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TIMER_IN(pin), .O_TIMER_OUT(tout),
    .O_PORT0_INPUT_MODE(pmode), .O_MASTER_INT(irq[0]), .O_CH1_INT(irq[1]), .O_UPPER_INT(irq[2]));
  // ==========
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic test_done;
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task automatic wrr(input logic [19:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task automatic rdr(input logic [19:0] a, output logic [7:0] d);
  begin
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  end
  endtask
  task automatic wait_irq(input int sel, input int lim, output int n);
  begin
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (irq[sel] !== 1'b1 && n < lim);
  end
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    logic [7:0] d;
  begin
    rdr(ADDR_FILTER_EN, d);
    check(d, 8'h00);
    rdr(ADDR_PORT0_DIR, d);
    check(d, 8'hff);
    check(pmode, 5'h1f);
    wrr(ADDR_PORT0_DIR, 8'h0a);
    rdr(ADDR_PORT0_DIR, d);
    check(d, 8'hea);
    check(pmode, 5'h0a);
    wrr(ADDR_FILTER_EN, 8'hff);
    rdr(ADDR_FILTER_EN, d);
    check(d, 8'h03);
    rdr(20'h0_0123, d);
    check(d, 8'h00);
  end
  endtask
  task automatic t_period;
    int n;
    logic [7:0] d;
  begin
    wrr(ADDR_RELOAD0_LO, 8'h02);
    wrr(ADDR_MODE0, 8'h04);
    for (int e = 0; e <= DIVB; e++)
    begin
      wrr(ADDR_PRESCALE, 8'(e));
      wrr(ADDR_START, 8'h01);
      wait_irq(0, 300, n);
      wait_irq(0, 300, n);
      check(n, 3 << e);
      wrr(ADDR_STOP, 8'h01);
      rdr(ADDR_STATUS, d);
      check(d[0], 1'b0);
    end
  end
  endtask
  task automatic t_event;
    int n[3];
    logic [7:0] f[3] = '{8'h00, 8'h01, 8'h02};
  begin
    wrr(ADDR_MODE0, 8'h09);
    wrr(ADDR_RELOAD0_LO, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wrr(ADDR_FILTER_EN, f[i]);
      wrr(ADDR_START, 8'h01);
      pins.drive(0, 1'b1);
      wait_irq(0, 40, n[i]);
      pins.drive(0, 1'b0);
      repeat (8) @(posedge clk);
      wrr(ADDR_STOP, 8'h01);
    end
    check(n[0] < 40, 1'b1);
    check(n[1], n[0] + 2);
    check(n[2], n[0]);
    check(tout[0], 1'b1);
  end
  endtask
  task automatic t_nosplit;
    int n;
    logic [7:0] d;
  begin
    wrr(ADDR_PRESCALE, 8'h00);
    wrr(ADDR_MODE1, 8'h00);
    wrr(ADDR_RELOAD1_HI, 8'h01);
    wrr(ADDR_START, 8'h04);
    wait_irq(2, 20, n);
    check(n, 20);
    rdr(ADDR_STATUS, d);
    check(d[2:1], 2'b00);
    wrr(ADDR_START, 8'h02);
    rdr(ADDR_STATUS, d);
    check(d[2:1], 2'b01);
    wrr(ADDR_STOP, 8'h06);
  end
  endtask
  task automatic t_split;
    int n;
    logic [7:0] d;
  begin
    wrr(ADDR_PRESCALE, 8'h30);
    wrr(ADDR_MODE1, 8'ha0);
    wrr(ADDR_START, 8'h04);
    wait_irq(2, 20, n);
    check(n < 20, 1'b1);
    wait_irq(2, 100, n);
    check(n, 16);
    rdr(ADDR_STATUS, d);
    check(d[2:1], 2'b10);
    rdr(ADDR_RELOAD1_HI, d);
    check(d, 8'h00);
    wrr(ADDR_STOP, 8'h04);
    rdr(ADDR_STATUS, d);
    check(d[2], 1'b0);
    wrr(ADDR_MODE1, 8'h00);
  end
  endtask
  task automatic t_pair;
    int n;
    logic [7:0] d;
  begin
    wrr(ADDR_PRESCALE, 8'h01);
    wrr(ADDR_MODE0, 8'h00);
    wrr(ADDR_RELOAD0_LO, 8'h03);
    wrr(ADDR_RELOAD1_LO, 8'h01);
    wrr(ADDR_MODE1, 8'h14);
    wrr(ADDR_START, 8'h03);
    rdr(ADDR_STATUS, d);
    check(d[1:0], 2'b11);
    wait_irq(1, 40, n);
    wait_irq(1, 40, n);
    check(n, 4);
    wrr(ADDR_STOP, 8'h03);
    rdr(ADDR_STATUS, d);
    check(d[1:0], 2'b00);
    wrr(ADDR_START, 8'h01);
    rdr(ADDR_STATUS, d);
    check(d[1:0], 2'b11);
    wrr(ADDR_STOP, 8'h03);
  end
  endtask
  // ==========
  // run control
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      test_done;
    end
  end
  initial
  begin
    rst_b = 1'b0;
    addr = 20'h0_0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_period;
    t_event;
    t_nosplit;
    t_split;
    t_pair;
    test_done;
  end
endmodule
